// >>> testbench/sdram_mode_zero_burst_latency_test.sv
// Purpose: Self-checking bench for the base mode register block
// Assumes: APB answer taken at the edge where pready is high
// Notes:   Expected columns rebuilt from start, type and beat
`timescale 1ns/1ns
`default_nettype none
module sdram_mode_zero_burst_latency_test
  import smzbl_pkg::*;
;
  localparam int TWR_NS = 40;
  localparam int WR_CYC = (TWR_NS + 7) / 8;
  logic        sys_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        psel_in    = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in  = 1'b0;
  logic [11:0] paddr_in   = 12'h000;
  logic [31:0] pwdata_in  = 32'h00000000;
  logic [31:0] q;
  logic        e;
  wire  [31:0] prdata_out;
  wire  [2:0]  col_addr_in, rd_col_out, wr_col_out;
  wire         pready_out, pslverr_out, cke_in, rd_cmd_in, wr_cmd_in;
  wire         burst_select_address_bit_in, rd_beat_out, dq_drive_out;
  wire         wr_beat_out, loop_running_out;
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  int          cycles     = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  smzbl_top i_smzbl_top (.sys_clk_in, .reset_n_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .cke_in, .rd_cmd_in, .wr_cmd_in, .col_addr_in,
    .burst_select_address_bit_in, .rd_col_out, .rd_beat_out,
    .dq_drive_out, .wr_col_out, .wr_beat_out, .loop_running_out);
  smzbl_ctrl_model i_smzbl_ctrl_model (.clk_in(sys_clk_in),
    .cke_out(cke_in), .rd_out(rd_cmd_in), .wr_out(wr_cmd_in),
    .col_out(col_addr_in), .a12_out(burst_select_address_bit_in));
  task automatic close_out();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask
  function automatic logic [31:0] mode(input logic [1:0] bl,
      input logic bt, input logic [2:0] cl, input logic dl, input logic pd);
    return {19'h0, pd, 3'(WR_CYC - 4), dl, 1'b0, cl, bt, 1'b0, bl};
  endfunction
  task automatic set_mode(input logic [31:0] v);
    apb(1'b1, ADDR_MODE, v);
    apb(1'b0, ADDR_MODE, 32'h00000000);
    check(q, v & ~32'(DLLR_MASK));
  endtask
  task automatic rd_burst(input logic [2:0] s, input logic il,
                          input logic a, input logic ch, input int lat);
    logic [2:0] i;
    logic       b;
    i_smzbl_ctrl_model.issue(1'b1, s, a);
    for (int j = 1; j < lat + 8; j++) begin
      @(posedge sys_clk_in);
      #1;
      i = 3'(j - lat);
      b = j >= lat && (!ch || j < lat + 4);
      check(rd_beat_out, b);
      check(dq_drive_out, b);
      if (b) begin
        check(rd_col_out, il ? s ^ i : {s[2] ^ i[2], s[1:0] + i[1:0]});
      end
    end
  endtask
  task automatic wr_burst(input logic [2:0] s, input logic ch);
    logic [2:0] i;
    logic       b;
    i_smzbl_ctrl_model.issue(1'b0, s, 1'b1);
    for (int j = 0; j < 8; j++) begin
      #1;
      i = 3'(j);
      b = !ch || j < 4;
      check(wr_beat_out, b);
      if (b) begin
        check(wr_col_out, {ch ? s[2] : i[2], i[1:0]});
      end
      @(posedge sys_clk_in);
    end
    repeat (16) @(posedge sys_clk_in);
  endtask
  task automatic t_reset();
    apb(1'b0, ADDR_MODE, 32'h00000000);
    check(q, 32'(MR_RESET));
    apb(1'b0, 12'h008, 32'h00000000);
    check(q, 32'h00000000);
    check(e, 1'b1);
  endtask
  // Reserved latency code: flagged on the mode write and on the command
  task automatic t_resv();
    set_mode(mode(2'h0, 1'b0, 3'h0, 1'b0, 1'b0));
    apb(1'b0, ADDR_STAT, 32'h00000000);
    check(q[S_RESV], 1'b1);
    apb(1'b1, ADDR_STAT, 32'h00000001 << S_RESV);
    apb(1'b0, ADDR_STAT, 32'h00000000);
    check(q[S_RESV], 1'b0);
    i_smzbl_ctrl_model.issue(1'b1, 3'h0, 1'b1);
    repeat (12) begin
      @(posedge sys_clk_in);
      #1;
      check(rd_beat_out, 1'b0);
    end
    apb(1'b0, ADDR_STAT, 32'h00000000);
    check(q[S_RESV], 1'b1);
  endtask
  task automatic t_restart();
    set_mode(mode(2'h0, 1'b0, 3'h1, 1'b1, 1'b0));
    apb(1'b0, ADDR_STAT, 32'h00000000);
    check(q[S_LOCKED], 1'b0);
    i_smzbl_ctrl_model.lock_wait();
    apb(1'b0, ADDR_STAT, 32'h00000000);
    check(q[S_LOCKED], 1'b1);
  endtask
  task automatic t_order();
    logic ch;
    logic a;
    for (int m = 0; m < 4; m++) begin
      for (int t = 0; t < 2; t++) begin
        set_mode(mode(2'(m), t[0], 3'h1, 1'b0, 1'b0));
        for (int s = 0; s < 8; s++) begin
          a = s[1];
          ch = m == 2 || (m == 1 && !a);
          rd_burst(3'(s), t[0], a, ch, 5);
        end
      end
    end
  endtask
  task automatic t_latency();
    for (int c = 1; c < 7; c++) begin
      set_mode(mode(2'h0, 1'b1, 3'(c), 1'b0, 1'b0));
      rd_burst(3'h6, 1'b1, 1'b1, 1'b0, c + 4);
    end
  endtask
  task automatic t_write();
    set_mode(mode(2'h2, 1'b1, 3'h1, 1'b0, 1'b0));
    wr_burst(3'h7, 1'b1);
    set_mode(mode(2'h0, 1'b1, 3'h1, 1'b0, 1'b0));
    wr_burst(3'h5, 1'b0);
  endtask
  task automatic t_pd();
    for (int p = 1; p >= 0; p--) begin
      set_mode(mode(2'h0, 1'b0, 3'h1, 1'b0, p[0]));
      i_smzbl_ctrl_model.set_cke(1'b0);
      repeat (3) @(posedge sys_clk_in);
      #1;
      check(loop_running_out, p[0]);
      i_smzbl_ctrl_model.set_cke(1'b1);
    end
  endtask
  // Whole run is near 1700 cycles; the ceiling leaves room
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_restart();
    t_order();
    t_latency();
    t_write();
    t_pd();
    t_resv();
    close_out();
  end
endmodule // sdram_mode_zero_burst_latency_test
`default_nettype wire

// >>> testbench/smzbl_ctrl_model.sv
// Purpose: Controller model driving commands and clock enable
// Assumes: Signals change by NBA just after a rising edge
// Notes:   Released address lines invert so stale values never match
`timescale 1ns/1ns
`default_nettype none
module smzbl_ctrl_model
  import smzbl_pkg::*;
(
  input  wire logic       clk_in,
  output logic            cke_out,
  output logic            rd_out,
  output logic            wr_out,
  output logic      [2:0] col_out,
  output logic            a12_out
);
  initial begin
    cke_out = 1'b1;
    rd_out  = 1'b0;
    wr_out  = 1'b0;
    col_out = 3'h0;
    a12_out = 1'b0;
  end
  // One command cycle, only the two burst forms
  task automatic issue(input logic rd, input logic [2:0] c,
                       input logic a);
    @(posedge clk_in);
    rd_out  <= rd;
    wr_out  <= !rd;
    col_out <= c;
    a12_out <= a;
    @(posedge clk_in);
    rd_out  <= 1'b0;
    wr_out  <= 1'b0;
    col_out <= ~c;
    a12_out <= !a;
  endtask
  // Clock enable high through the lock wait
  task automatic lock_wait();
    cke_out <= 1'b1;
    repeat (512) @(posedge clk_in);
  endtask
  // Longer exit wait covers both loop choices
  task automatic set_cke(input logic v);
    @(posedge clk_in);
    cke_out <= v;
    if (v) begin
      repeat (SLOW_EXIT_CYC + 1) @(posedge clk_in);
    end
  endtask
endmodule // smzbl_ctrl_model
`default_nettype wire

// >>> verilog/smzbl_order.sv
// Purpose: Column of one read beat from start column and burst type
// Assumes: Beat index 0..7; chopped bursts only use beats 0..3
// Notes:   Beats 4..7 of a sequential burst land in the other nibble
`timescale 1ns/1ns
`default_nettype none
module smzbl_order
  import smzbl_pkg::*;
(
  smzbl_order_if.orderer ord
);
  wire [1:0] seq_low = ord.start_col[1:0] + ord.beat[1:0];
  wire [2:0] seq_col = {ord.start_col[2] ^ ord.beat[2], seq_low};
  wire [2:0] ilv_col = ord.start_col ^ ord.beat;
  // Interleaved is start XOR beat; sequential wraps in nibble
  assign ord.col = ord.interleave ? ilv_col : seq_col;
endmodule // smzbl_order
`default_nettype wire

// >>> verilog/smzbl_order_if.sv
// Purpose: Carries a burst start, type and beat to the column orderer
// Assumes: Combinational answer
// Notes:   None
`timescale 1ns/1ns
`default_nettype none
interface smzbl_order_if;
  logic [2:0] start_col;
  logic       interleave;
  logic [2:0] beat;
  logic [2:0] col;
  modport requester (output start_col, output interleave,
                     output beat, input col);
  modport orderer   (input start_col, input interleave,
                     input beat, output col);
endinterface
`default_nettype wire

// >>> verilog/smzbl_pkg.sv
// Purpose: Shared constants and types for the base mode register block
// Assumes: 125 MHz command clock, APB register access
// Notes:   Latency and recovery tables map field codes to cycles
package smzbl_pkg;

  localparam int unsigned CLK_MHZ = 125;

  // APB map, byte addresses within the block
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;

  // Base mode register layout
  localparam int unsigned MR_W      = 17;
  localparam logic [16:0] MR_RESET  = 17'h00000;
  localparam logic [16:0] MR_WMASK  = 17'h01F7B;
  localparam logic [16:0] DLLR_MASK = 17'h00100;
  localparam int unsigned BL_LSB    = 0;
  localparam int unsigned BL_MSB    = 1;
  localparam int unsigned BT_BIT    = 3;
  localparam int unsigned CL_LSB    = 4;
  localparam int unsigned CL_MSB    = 6;
  localparam int unsigned DLLR_BIT  = 8;
  localparam int unsigned WR_LSB    = 9;
  localparam int unsigned WR_MSB    = 11;
  localparam int unsigned PPD_BIT   = 12;

  // Burst length field codes
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_CHOP   = 2'h2;

  // Field code to cycles; zero marks a reserved code
  localparam logic [3:0] CL_CYC_TBL [0:7] =
    '{4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'h0};
  localparam logic [3:0] WR_CYC_TBL [0:7] =
    '{4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC, 4'h0};

  // Burst geometry
  localparam logic [2:0] LAST_BEAT = 3'h7;

  // Timing
  localparam logic [9:0]  LOCK_WAIT_CYC = 10'h200;
  localparam int unsigned SLOW_EXIT_NS  = 24;
  localparam int unsigned FAST_EXIT_NS  = 6;
  localparam logic [3:0]  SLOW_EXIT_CYC =
    4'((SLOW_EXIT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0]  FAST_EXIT_CYC =
    4'((FAST_EXIT_NS * CLK_MHZ + 999) / 1000);

  // Status register bits
  localparam int unsigned S_LOCKED = 0;
  localparam int unsigned S_EARLY  = 1;
  localparam int unsigned S_RESV   = 2;
  localparam int unsigned S_RECOV  = 3;
  localparam int unsigned S_PD     = 4;
  localparam int unsigned S_LOOP   = 5;
  localparam int unsigned S_EXIT   = 6;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_LAT  = 2'b01,
    SEQ_BEAT = 2'b10
  } smzbl_seq_t;

endpackage

// >>> verilog/smzbl_top.sv
// Purpose: Base mode register, burst ordering, latency and loop control
// Assumes: APB slave, zero wait; commands sampled on sys_clk_in
// Notes:   Columns stand for data beats; dq_drive_out gates DQ and DQS
//
// Function
// - Burst type bit picks sequential or interleaved ordering.
// - Column order follows burst length, type, low start bits.
// - Only four-beat chopped and eight-beat bursts exist.
// - Reads start anywhere; writes start on block boundaries.
// - Eight-beat sequential read wraps nibble, then other nibble.
// - Eight-beat interleaved read column is start XOR beat.
// - Chopped sequential read: four wrapped beats, four idle slots.
// - Chopped interleaved read: start XOR beat, four idle slots.
// - Chopped write uses column bit 2 only, drops last four.
// - Eight-beat write stores columns 0 to 7 ascending.
// - Chopped bursts start internally when eight-beat ones do.
// - Loop restart bit starts a restart, then clears itself.
// - Write recovery field gives 5, 6, 7, 8, 10 or 12 cycles.
// - Bit zero stops loop in powerdown; slow exit time applies.
// - Bit one keeps loop running in powerdown; fast exit applies.
// - Read latency field gives whole 5 to 10 cycles.
// - Read at edge n, latency m: first beat at edge n+m.
// - On-the-fly mode: address bit 12 low chops, high is eight.
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module smzbl_top
  import smzbl_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        cke_in,
  input  wire logic        rd_cmd_in,
  input  wire logic        wr_cmd_in,
  input  wire logic [2:0]  col_addr_in,
  input  wire logic        burst_select_address_bit_in,
  output logic      [2:0]  rd_col_out,
  output logic             rd_beat_out,
  output logic             dq_drive_out,
  output logic      [2:0]  wr_col_out,
  output logic             wr_beat_out,
  output logic             loop_running_out
);

  logic [16:0] mr_ff;
  logic [31:0] prdata_ff;
  logic [9:0]  lock_cnt_ff;
  logic        locked_ff;
  logic        early_ff;
  logic        resv_ff;
  logic        pd_ff;
  logic [3:0]  exit_cnt_ff;
  smzbl_seq_t  rd_state_ff;
  smzbl_seq_t  nxt_rd_state;
  logic [3:0]  rd_wait_ff;
  logic [2:0]  rd_idx_ff;
  logic [2:0]  rd_start_ff;
  logic        rd_chop_ff;
  logic        rd_ilv_ff;
  logic [2:0]  rd_col_ff;
  logic        rd_valid_ff;
  logic        dq_oe_ff;
  smzbl_seq_t  wr_state_ff;
  logic [2:0]  wr_idx_ff;
  logic        wr_base_ff;
  logic        wr_chop_ff;
  logic [3:0]  wr_lat_ff;
  logic [3:0]  rec_cnt_ff;
  logic [2:0]  wr_col_ff;
  logic        wr_en_ff;
  logic [31:0] stat_word;

  // APB decode; zero wait so pready is constant
  wire apb_acc  = psel_in & penable_in;
  wire hit_mode = (paddr_in == ADDR_MODE);
  wire hit_stat = (paddr_in == ADDR_STAT);
  wire hit_any  = hit_mode | hit_stat;
  wire wr_mode  = apb_acc & pwrite_in & hit_mode;
  wire wr_stat  = apb_acc & pwrite_in & hit_stat;
  wire rd_setup = psel_in & ~penable_in & ~pwrite_in;
  assign pready_out  = 1'b1;
  assign pslverr_out = apb_acc & ~hit_any;

  // Mode fields
  wire [1:0] bl_mode = mr_ff[BL_MSB:BL_LSB];
  wire       ilv_sel = mr_ff[BT_BIT];
  wire [3:0] cl_cyc  = CL_CYC_TBL[mr_ff[CL_MSB:CL_LSB]];
  wire [3:0] wr_cyc  = WR_CYC_TBL[mr_ff[WR_MSB:WR_LSB]];
  wire       restart = mr_ff[DLLR_BIT];
  // Code 11 falls back to eight beats: no third burst form
  wire       chop_sel = (bl_mode == BL_OTF) ?
                        ~burst_select_address_bit_in :
                        (bl_mode == BL_CHOP);

  // Reserved codes in a new mode word are flagged, not corrected
  wire [2:0] new_cl  = pwdata_in[CL_MSB:CL_LSB];
  wire [2:0] new_wr  = pwdata_in[WR_MSB:WR_LSB];
  wire       bad_new = wr_mode & ((CL_CYC_TBL[new_cl] == 4'h0) |
                                  (WR_CYC_TBL[new_wr] == 4'h0));

  // Reserved bits never store; restart bit lives one cycle only
  wire [16:0] nxt_mr = wr_mode ? (pwdata_in[16:0] & MR_WMASK)
                               : (mr_ff & ~DLLR_MASK);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mr_ff <= MR_RESET;
    end else begin
      mr_ff <= nxt_mr;
    end
  end

  // Loop lock wait; only cycles with clock enable high count
  wire       lock_run     = (lock_cnt_ff != 10'h000) & cke_in;
  wire [9:0] nxt_lock_cnt = restart  ? LOCK_WAIT_CYC :
                            lock_run ? lock_cnt_ff - 10'h001 :
                            lock_cnt_ff;
  wire       nxt_locked   = restart ? 1'b0 :
                            (lock_run & (lock_cnt_ff == 10'h001)) ? 1'b1 :
                            locked_ff;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lock_cnt_ff <= 10'h000;
      locked_ff   <= 1'b0;
    end else begin
      lock_cnt_ff <= nxt_lock_cnt;
      locked_ff   <= nxt_locked;
    end
  end

  // Precharge powerdown: clock enable low with both sequencers idle
  wire seq_idle  = (rd_state_ff == SEQ_IDLE) & (wr_state_ff == SEQ_IDLE);
  wire pd_enter  = ~pd_ff & ~cke_in & seq_idle;
  wire pd_exit   = pd_ff & cke_in;
  wire nxt_pd    = pd_enter | (pd_ff & ~cke_in);
  wire loop_stop = pd_ff & ~mr_ff[PPD_BIT];
  wire [3:0] exit_load = loop_stop ? SLOW_EXIT_CYC :
                                     FAST_EXIT_CYC;
  wire [3:0] nxt_exit_cnt = pd_exit ? exit_load :
                            (exit_cnt_ff != 4'h0) ? exit_cnt_ff - 4'h1 :
                            exit_cnt_ff;
  wire cmd_ok = cke_in & ~pd_ff & (exit_cnt_ff == 4'h0);
  assign loop_running_out = locked_ff & ~loop_stop;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pd_ff       <= 1'b0;
      exit_cnt_ff <= 4'h0;
    end else begin
      pd_ff       <= nxt_pd;
      exit_cnt_ff <= nxt_exit_cnt;
    end
  end

  // Command acceptance; a read wins a same-cycle write
  wire rd_idle = (rd_state_ff == SEQ_IDLE);
  wire wr_idle = (wr_state_ff == SEQ_IDLE);
  wire rd_try  = rd_cmd_in & cmd_ok & rd_idle & wr_idle;
  wire wr_try  = wr_cmd_in & ~rd_cmd_in & cmd_ok & rd_idle & wr_idle;
  wire rd_go   = rd_try & (cl_cyc != 4'h0);
  wire wr_go   = wr_try & (wr_cyc != 4'h0);
  wire bad_cmd = (rd_try & ~rd_go) | (wr_try & ~wr_go);

  // Read sequencer
  wire rd_lat_end = (rd_state_ff == SEQ_LAT) & (rd_wait_ff == 4'h1);
  wire rd_more    = (rd_state_ff == SEQ_BEAT) & (rd_idx_ff != LAST_BEAT);
  wire rd_ld      = rd_lat_end | rd_more;
  wire [2:0] rd_nxt_idx = rd_lat_end ? 3'h0 : rd_idx_ff + 3'h1;
  // Chopped bursts still occupy eight slots; last four undriven
  wire rd_live    = rd_ld & (~rd_chop_ff | ~rd_nxt_idx[2]);

  always_comb begin
    nxt_rd_state = rd_state_ff;
    unique case (rd_state_ff)
      SEQ_IDLE: begin
        if (rd_go) begin
          nxt_rd_state = SEQ_LAT;
        end
      end
      SEQ_LAT: begin
        if (rd_lat_end) begin
          nxt_rd_state = SEQ_BEAT;
        end
      end
      SEQ_BEAT: begin
        if (!rd_more) begin
          nxt_rd_state = SEQ_IDLE;
        end
      end
      default: begin
        nxt_rd_state = SEQ_IDLE;
      end
    endcase
  end

  smzbl_order_if ord_if ();
  assign ord_if.start_col  = rd_start_ff;
  assign ord_if.interleave = rd_ilv_ff;
  assign ord_if.beat       = rd_nxt_idx;

  smzbl_order u_order (
    .ord (ord_if)
  );

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_state_ff <= SEQ_IDLE;
      rd_wait_ff  <= 4'h0;
      rd_idx_ff   <= 3'h0;
      rd_start_ff <= 3'h0;
      rd_chop_ff  <= 1'b0;
      rd_ilv_ff   <= 1'b0;
    end else begin
      rd_state_ff <= nxt_rd_state;
      if (rd_go) begin
        rd_wait_ff  <= cl_cyc;
        rd_start_ff <= col_addr_in;
        rd_chop_ff  <= chop_sel;
        rd_ilv_ff   <= ilv_sel;
      end else if (rd_state_ff == SEQ_LAT) begin
        rd_wait_ff <= rd_wait_ff - 4'h1;
      end
      if (rd_ld) begin
        rd_idx_ff <= rd_nxt_idx;
      end
    end
  end

  // Registered beat outputs; columns hold after the burst
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_col_ff   <= 3'h0;
      rd_valid_ff <= 1'b0;
      dq_oe_ff    <= 1'b0;
    end else begin
      rd_valid_ff <= rd_live;
      dq_oe_ff    <= rd_live;
      if (rd_ld) begin
        rd_col_ff <= ord_if.col;
      end
    end
  end
  assign rd_col_out   = rd_col_ff;
  assign rd_beat_out  = rd_valid_ff;
  assign dq_drive_out = dq_oe_ff;

  // Write sequencer: same slot count for both forms
  wire wr_more = (wr_state_ff == SEQ_BEAT) & (wr_idx_ff != LAST_BEAT);
  wire wr_ld   = wr_go | wr_more;
  wire wr_end  = (wr_state_ff == SEQ_BEAT) & ~wr_more;
  wire [2:0] wr_nxt_idx = wr_go ? 3'h0 : wr_idx_ff + 3'h1;
  wire       wr_nchop   = wr_go ? chop_sel : wr_chop_ff;
  wire       wr_nbase   = wr_go ? col_addr_in[2] : wr_base_ff;
  // Low start bits never reach the column; writes start aligned
  wire [2:0] wr_ncol    = wr_nchop ? {wr_nbase, wr_nxt_idx[1:0]}
                                   : wr_nxt_idx;
  wire       wr_live    = wr_ld & (~wr_nchop | ~wr_nxt_idx[2]);
  wire [3:0] nxt_rec    = wr_end ? wr_lat_ff :
                          (rec_cnt_ff != 4'h0) ? rec_cnt_ff - 4'h1 :
                          rec_cnt_ff;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_state_ff <= SEQ_IDLE;
      wr_idx_ff   <= 3'h0;
      wr_base_ff  <= 1'b0;
      wr_chop_ff  <= 1'b0;
      wr_lat_ff   <= 4'h0;
    end else begin
      if (wr_go) begin
        wr_state_ff <= SEQ_BEAT;
        wr_base_ff  <= col_addr_in[2];
        wr_chop_ff  <= chop_sel;
        wr_lat_ff   <= wr_cyc;
      end else if (wr_end) begin
        wr_state_ff <= SEQ_IDLE;
      end
      if (wr_ld) begin
        wr_idx_ff <= wr_nxt_idx;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_col_ff  <= 3'h0;
      wr_en_ff   <= 1'b0;
      rec_cnt_ff <= 4'h0;
    end else begin
      wr_en_ff   <= wr_live;
      rec_cnt_ff <= nxt_rec;
      if (wr_ld) begin
        wr_col_ff <= wr_ncol;
      end
    end
  end
  assign wr_col_out  = wr_col_ff;
  assign wr_beat_out = wr_en_ff;

  // Sticky flags; a set in the clearing cycle survives
  wire early_set = rd_go & ~locked_ff;
  wire early_clr = wr_stat & pwdata_in[S_EARLY];
  wire resv_set  = bad_new | bad_cmd;
  wire resv_clr  = wr_stat & pwdata_in[S_RESV];

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      early_ff <= 1'b0;
      resv_ff  <= 1'b0;
    end else begin
      early_ff <= early_set | (early_ff & ~early_clr);
      resv_ff  <= resv_set | (resv_ff & ~resv_clr);
    end
  end

  always_comb begin
    stat_word           = 32'h0000_0000;
    stat_word[S_LOCKED] = locked_ff;
    stat_word[S_EARLY]  = early_ff;
    stat_word[S_RESV]   = resv_ff;
    stat_word[S_RECOV]  = (rec_cnt_ff != 4'h0);
    stat_word[S_PD]     = pd_ff;
    stat_word[S_LOOP]   = loop_running_out;
    stat_word[S_EXIT]   = (exit_cnt_ff != 4'h0);
  end

  // Read data captured in setup, stable through access
  wire [31:0] rd_word = hit_mode ? {15'h0000, mr_ff} :
                        hit_stat ? stat_word : 32'h0000_0000;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_ff <= rd_word;
    end
  end
  assign prdata_out = prdata_ff;

  // Checking helpers
  logic [3:0] rd_age_ff;
  logic [3:0] rd_lat_ff;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_age_ff <= 4'h0;
      rd_lat_ff <= 4'h0;
    end else if (rd_go) begin
      rd_age_ff <= 4'h0;
      rd_lat_ff <= cl_cyc;
    end else if (rd_age_ff != 4'hF) begin
      rd_age_ff <= rd_age_ff + 4'h1;
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_restart_clears: assert property (
    (restart && !wr_mode) |=> !restart ##0 lock_cnt_ff == LOCK_WAIT_CYC)
    else $error("restart bit did not clear or wait not loaded");
  a_lock_wait_hold: assert property (
    restart |=> !locked_ff [*8])
    else $error("loop reported locked too soon after restart");
  a_first_beat_lat: assert property (
    $rose(rd_valid_ff) |-> (rd_age_ff == rd_lat_ff) &&
                           (rd_col_ff == rd_start_ff))
    else $error("first read beat not at programmed latency");
  a_chop_rd_float: assert property (
    ($rose(rd_valid_ff) && rd_chop_ff) |->
      dq_oe_ff [*4] ##1 !dq_oe_ff [*4])
    else $error("chopped read slots driven wrongly");
  a_seq_rd_nibble: assert property (
    ($rose(rd_valid_ff) && !rd_ilv_ff && !rd_chop_ff) |->
      ##1 rd_col_ff[1:0] == rd_start_ff[1:0] + 2'h1
      ##3 rd_col_ff == {~rd_start_ff[2], rd_start_ff[1:0]})
    else $error("sequential read order wrong");
  a_ilv_rd_order: assert property (
    ($rose(rd_valid_ff) && rd_ilv_ff && !rd_chop_ff) |->
      ##7 rd_col_ff == (rd_start_ff ^ LAST_BEAT))
    else $error("interleaved read order wrong");
  a_chop_ilv_rd: assert property (
    ($rose(rd_valid_ff) && rd_ilv_ff && rd_chop_ff) |->
      ##3 rd_col_ff == (rd_start_ff ^ 3'h3))
    else $error("chopped interleaved order wrong");
  a_full_wr_cols: assert property (
    ($rose(wr_en_ff) && !wr_chop_ff) |->
      wr_col_ff == 3'h0 ##7 wr_col_ff == LAST_BEAT && wr_en_ff)
    else $error("eight-beat write columns wrong");
  a_chop_wr_cols: assert property (
    ($rose(wr_en_ff) && wr_chop_ff) |->
      wr_col_ff == {wr_base_ff, 2'h0} ##4 !wr_en_ff [*4])
    else $error("chopped write columns wrong");
  a_pd_loop_stop: assert property (
    (pd_ff && !mr_ff[PPD_BIT]) |-> !loop_running_out)
    else $error("loop still running in slow powerdown");
  a_pd_loop_keep: assert property (
    (pd_ff && mr_ff[PPD_BIT] && locked_ff) |-> loop_running_out)
    else $error("loop stopped in fast powerdown");

  c_chop_read: cover property (
    $rose(rd_valid_ff) && rd_chop_ff);
  c_ilv_full_read: cover property (
    $rose(rd_valid_ff) && rd_ilv_ff && !rd_chop_ff);
  c_lock_done: cover property ($rose(locked_ff));
  c_pd_exit: cover property ($fell(pd_ff) ##1 exit_cnt_ff != 4'h0);

endmodule // smzbl_top
`default_nettype wire
